// *** common/clfb_pkg.sv ***
package clfb_pkg;
  // register map: printed offset feedback_loop_control is not a multiple of four, so it is an index
  localparam logic [7:0]  REG_IDX_FB_LOOP_CTRL = 8'h23;
  localparam logic [31:0] ADDR_FB_LOOP_CTRL    = 32'h0000_008c;
  localparam logic [7:0]  ADDR_IDX_STATUS      = 8'h24;
  localparam logic [31:0] ADDR_STATUS          = 32'h0000_0090;
  localparam int          ADDR_W               = 12;

  // field positions
  localparam int NG_BIT        = 7;
  localparam int BRAKE_LSB     = 4;
  localparam int BRAKE_MSB     = 6;
  localparam int LOOP_LSB      = 2;
  localparam int LOOP_MSB      = 3;
  localparam int BEMF_LSB      = 0;
  localparam int BEMF_MSB      = 1;

  // reset value: ng 0, brake 3, loop 1, bemf 2
  localparam logic [7:0] FB_LOOP_CTRL_RST = 8'h36;

  localparam logic [2:0] BRAKE_CODE_OFF = 3'h7;

  // noise gate thresholds on an 8-bit magnitude scale (full = 255)
  localparam logic [7:0] NG_THR_LOW  = 8'h0a;
  localparam logic [7:0] NG_THR_HIGH = 8'h14;

  // ahb-lite
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage

// *** dv/clfb_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module clfb_chk (
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic       braking_i,
  input wire logic       drive_vld_i,
  input wire logic [7:0] drive_mag_i,
  input wire logic [7:0] out_mag_o,
  input wire logic [4:0] brake_ratio_o,
  input wire logic       brake_fb_en_o,
  input wire logic       hreadyout_o,
  input wire logic       hresp_o,
  input wire logic       hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic       hwrite_i,
  input wire logic [1:0] loop_speed_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  gate_low_a: assert property (drive_vld_i && drive_mag_i < 8'h0a |=> out_mag_o == '0)
    else $error("small drive passed");
  pass_big_a: assert property (drive_vld_i && !braking_i && drive_mag_i >= 8'h14
    |=> out_mag_o == $past(drive_mag_i)) else $error("big drive lost");
  ratio_code_a: assert property (brake_fb_en_o |-> brake_ratio_o inside
    {5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h10}) else $error("bad ratio");
  ratio_off_a: assert property (!brake_fb_en_o |-> brake_ratio_o == '0)
    else $error("ratio while off");
  brake_off_a: assert property (drive_vld_i && braking_i && !brake_fb_en_o
    |=> out_mag_o == '0) else $error("braking drive passed");
  // only a host write may move the loop field
  loop_hold_a: assert property (!$past(hsel_i && htrans_i == 2'h2 && hwrite_i, 2)
    |-> $stable(loop_speed_o)) else $error("loop speed moved");
  bus_ok_a: assert property (hreadyout_o && !hresp_o) else $error("bus not okay");
endmodule
`default_nettype wire

// *** dv/test_closed_loop_feedback_config.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_closed_loop_feedback_config;
  logic        sys_clk_i = '0, rst_n_i = '0, clk_en_i = '1, hsel_i = '1, hwrite_i = '0;
  logic        cal_wr_i = '0, cal_busy_i = '0, braking_i = '0, drive_vld_i = '0, drive_neg_i = '0;
  logic        hreadyout_o, hresp_o, out_neg_o, brake_fb_en_o;
  logic [1:0]  htrans_i = '0, cal_backemf_amp_gain_i = '0, loop_speed_o, backemf_amp_gain_o;
  logic [2:0]  hsize_i = clfb_pkg::HSIZE_WORD;
  logic [4:0]  brake_ratio_o;
  logic [7:0]  drive_mag_i = '0, out_mag_o, v;
  logic [31:0] haddr_i = '0, hwdata_i = '0, hrdata_o, rd;
  logic [4:0]  rt [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h10, 5'h00};
  int          failures = 0, samples_checked = 0;
  wire         hready_i = hreadyout_o;
  initial forever #4 sys_clk_i = ~sys_clk_i;
  clfb_top dut (.*);
  task chk(input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %0t %h %h", $time, s, e);
    end
  endtask
  task results;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ready and read data are taken at the rising edge that ends the phase
  task wt;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 50);
    rd = hrdata_o;
    if (hreadyout_o !== 1'b1) begin
      failures++;
      results();
    end
  endtask
  task xf(input logic w, input logic [31:0] a, d);
    htrans_i <= clfb_pkg::HTRANS_NONSEQ;
    haddr_i <= a;
    hwrite_i <= w;
    wt();
    htrans_i <= clfb_pkg::HTRANS_IDLE;
    hwdata_i <= d;
    wt();
  endtask
  task dv(input logic [7:0] m, input logic b, input logic [7:0] e);
    drive_vld_i <= '1;
    drive_mag_i <= m;
    braking_i <= b;
    @(posedge sys_clk_i);
    drive_vld_i <= '0;
    @(negedge sys_clk_i);
    chk(out_mag_o, e);
    @(posedge sys_clk_i);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= '1;
    @(posedge sys_clk_i);
    xf('0, clfb_pkg::ADDR_FB_LOOP_CTRL, '0);
    chk(rd, clfb_pkg::FB_LOOP_CTRL_RST);
    chk({brake_ratio_o, loop_speed_o, backemf_amp_gain_o}, {5'h04, 2'h1, 2'h2});
    for (int i = 0; i < 8; i++) begin
      v = {i[0], i[2:0], i[1:0], ~i[1:0]};
      xf('1, clfb_pkg::ADDR_FB_LOOP_CTRL, v);
      xf('0, clfb_pkg::ADDR_FB_LOOP_CTRL, '0);
      chk(rd, v);
      chk({brake_ratio_o, brake_fb_en_o, loop_speed_o, backemf_amp_gain_o},
          {rt[i], i != 7, i[1:0], ~i[1:0]});
      dv(8'h10, '0, i[0] ? 8'h00 : 8'h10);
      dv(8'h14, '0, 8'h14);
      dv(8'h09, '0, 8'h00);
      dv(8'h40, '1, i == 7 ? 8'h00 : 8'h40);
    end
    xf('1, 32'h0, 32'hff);
    xf('0, 32'h0, '0);
    chk(rd, '0);
    xf('1, clfb_pkg::ADDR_FB_LOOP_CTRL, 32'h36);
    cal_busy_i <= '1;
    @(posedge sys_clk_i);
    cal_wr_i <= '1;
    cal_backemf_amp_gain_i <= 2'h1;
    @(posedge sys_clk_i);
    cal_wr_i <= '0;
    cal_busy_i <= '0;
    xf('0, clfb_pkg::ADDR_STATUS, '0);
    chk(rd, 32'h2);
    xf('0, clfb_pkg::ADDR_FB_LOOP_CTRL, '0);
    chk(rd, 32'h35);
    xf('1, clfb_pkg::ADDR_FB_LOOP_CTRL, 32'h35);
    xf('0, clfb_pkg::ADDR_STATUS, '0);
    chk(rd, 32'h3);
    results();
  end
endmodule
bind clfb_top clfb_chk u_chk (.*);
`default_nettype wire

// *** hdl/clfb_brake_ratio.sv ***
`timescale 1ns/10ps
`default_nettype none
module clfb_brake_ratio (
  input  wire logic [2:0] code_i,
  output logic      [4:0] ratio_o,
  output logic            brake_en_o
);
  always_comb begin
    brake_en_o = 1'b1;
    case (code_i)
      3'h0: ratio_o = 5'h01;
      3'h1: ratio_o = 5'h02;
      3'h2: ratio_o = 5'h03;
      3'h3: ratio_o = 5'h04;
      3'h4: ratio_o = 5'h06;
      3'h5: ratio_o = 5'h08;
      3'h6: ratio_o = 5'h10;
      default: begin
        ratio_o    = 5'h00;
        brake_en_o = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// *** hdl/clfb_top.sv ***
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module clfb_top (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        cal_wr_i,
  input  wire logic [1:0]  cal_backemf_amp_gain_i,
  input  wire logic        cal_busy_i,
  input  wire logic        braking_i,
  input  wire logic        drive_vld_i,
  input  wire logic        drive_neg_i,
  input  wire logic [7:0]  drive_mag_i,
  output logic             out_neg_o,
  output logic      [7:0]  out_mag_o,
  output logic      [4:0]  brake_ratio_o,
  output logic             brake_fb_en_o,
  output logic      [1:0]  loop_speed_o,
  output logic      [1:0]  backemf_amp_gain_o
);

  typedef struct packed {
    logic        wr_pend;
    logic [31:0] wr_addr;
    logic [7:0]  ctrl;
    logic        cfg_after_cal;
    logic [31:0] rdata;
    logic        out_neg;
    logic [7:0]  out_mag;
  } clfb_state_t;

  clfb_state_t s_q;
  clfb_state_t s_d;

  logic [4:0] ratio_w;
  logic       brake_en_w;
  logic       ng_sel_w;
  logic [7:0] thr_w;
  logic       rd_req_w;
  logic       wr_hit_w;

  clfb_brake_ratio u_ratio (
    .code_i     (s_q.ctrl[clfb_pkg::BRAKE_MSB:clfb_pkg::BRAKE_LSB]),
    .ratio_o    (ratio_w),
    .brake_en_o (brake_en_w)
  );

  assign ng_sel_w = s_q.ctrl[clfb_pkg::NG_BIT];
  assign rd_req_w = hsel_i && hready_i && htrans_i == clfb_pkg::HTRANS_NONSEQ && !hwrite_i;
  assign wr_hit_w = s_q.wr_pend && s_q.wr_addr == clfb_pkg::ADDR_FB_LOOP_CTRL;

  always_comb begin
    s_d = s_q;
    thr_w = ng_sel_w ? clfb_pkg::NG_THR_HIGH : clfb_pkg::NG_THR_LOW;
    s_d.wr_pend = 1'b0;
    if (hsel_i && hready_i && htrans_i == clfb_pkg::HTRANS_NONSEQ && hwrite_i) begin
      s_d.wr_pend = 1'b1;
      s_d.wr_addr = haddr_i;
    end
    // running calibration clears the status flag; a host write in the same cycle sets it
    if (cal_busy_i) begin
      s_d.cfg_after_cal = 1'b0;
    end
    if (wr_hit_w) begin
      s_d.ctrl = hwdata_i[7:0];
      // status: written since calibration
      s_d.cfg_after_cal = 1'b1;
    end
    // calibration stores gain, host write loses
    if (cal_wr_i) begin
      s_d.ctrl[clfb_pkg::BEMF_MSB:clfb_pkg::BEMF_LSB] = cal_backemf_amp_gain_i;
    end
    if (rd_req_w) begin
      if (haddr_i == clfb_pkg::ADDR_FB_LOOP_CTRL) begin
        s_d.rdata = {24'h000000, s_d.ctrl};
      end else if (haddr_i == clfb_pkg::ADDR_STATUS) begin
        s_d.rdata = {30'h00000000, brake_en_w, s_q.cfg_after_cal};
      end else begin
        s_d.rdata = 32'h00000000;
      end
    end
    if (drive_vld_i) begin
      s_d.out_neg = drive_neg_i;
      s_d.out_mag = drive_mag_i;
      if (drive_mag_i < thr_w) begin
        s_d.out_mag = 8'h00;
        s_d.out_neg = 1'b0;
      end
      // no feedback while braking with code 7
      if (braking_i && !brake_en_w) begin
        s_d.out_mag = 8'h00;
        s_d.out_neg = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q.wr_pend       <= 1'b0;
      s_q.wr_addr       <= 32'h00000000;
      s_q.ctrl          <= clfb_pkg::FB_LOOP_CTRL_RST;
      s_q.cfg_after_cal <= 1'b0;
      s_q.rdata         <= 32'h00000000;
      s_q.out_neg       <= 1'b0;
      s_q.out_mag       <= 8'h00;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  assign hrdata_o    = s_q.rdata;
  // zero wait states, always okay
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign out_neg_o   = s_q.out_neg;
  assign out_mag_o   = s_q.out_mag;
  assign brake_ratio_o = ratio_w;
  assign brake_fb_en_o = brake_en_w;
  assign loop_speed_o = s_q.ctrl[clfb_pkg::LOOP_MSB:clfb_pkg::LOOP_LSB];
  assign backemf_amp_gain_o = s_q.ctrl[clfb_pkg::BEMF_MSB:clfb_pkg::BEMF_LSB];

endmodule
`default_nettype wire
